// ---- logic/adpwm_consts.svh ----
`ifndef ADPWM_CONSTS_SVH
`define ADPWM_CONSTS_SVH

// ----------------------------------------
// Clock and pacing
// ----------------------------------------
`define ADPWM_MCLK_HZ          125000000
`define ADPWM_SAMPLE_RATE_HZ   11025
`define ADPWM_CARRIER_PER_SMP  4
// Carrier cycles per PWM period, rounded to nearest; a sample is exactly four periods
`define ADPWM_CARRIER_CYC      ((`ADPWM_MCLK_HZ + (`ADPWM_CARRIER_PER_SMP * `ADPWM_SAMPLE_RATE_HZ) / 2) / (`ADPWM_CARRIER_PER_SMP * `ADPWM_SAMPLE_RATE_HZ))

// ----------------------------------------
// Buffers
// ----------------------------------------
`define ADPWM_SEG_AW           7
`define ADPWM_SEG_DEPTH        128
`define ADPWM_GROUP_LEN        4
`define ADPWM_REC_BYTES        27563
`define ADPWM_REC_SAMPLES      (2 * `ADPWM_REC_BYTES)
`define ADPWM_PCM_MID          16'h8000

`endif

// ---- logic/adpwm_pkg.sv ----
package adpwm_pkg;

	typedef enum logic [2:0] {
		ST_IDLE        = 3'b000,
		ST_PLAY_REQ    = 3'b001,
		ST_PLAY_ACTIVE = 3'b010,
		ST_REC_REQ     = 3'b011,
		ST_RECORDING   = 3'b100,
		ST_REC_STOP    = 3'b101
	} adpwm_state_t;

	typedef logic [15:0] adpwm_pcm_t;
	typedef logic [11:0] adpwm_adc_t;

endpackage

// ---- logic/adpwm_carrier_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface adpwm_carrier_if;
	logic [15:0] dutyWord;
	logic        dutyLoad;
	logic        periodEnd;
	logic        pwmLevel;

	modport ctrl  (output dutyWord, output dutyLoad, input periodEnd, input pwmLevel);
	modport timer (input dutyWord, input dutyLoad, output periodEnd, output pwmLevel);
endinterface

`default_nettype wire

// ---- logic/adpwm_carrier.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adpwm_consts.svh"

module adpwm_carrier
	import adpwm_pkg::*;
	#(parameter int CARRIER_CYC = `ADPWM_CARRIER_CYC)
	(
	input  wire logic mclk,
	input  wire logic rst_b,
	adpwm_carrier_if.timer cif
	);

	localparam logic [11:0] CYC12 = 12'(CARRIER_CYC);
	localparam logic [11:0] LAST  = 12'(CARRIER_CYC - 1);

	logic [11:0] cntQ;
	logic [11:0] cmpQ;
	logic [15:0] pendQ;
	logic        pwmQ;
	logic        perEndQ;
	logic        wrap;
	logic [27:0] scaled;
	logic [11:0] cntNext;

	assign wrap    = (cntQ == LAST);
	assign cntNext = cntQ + 12'h001;
	// Offset-binary PCM scaled onto one carrier period
	// Both factors widened first so the product keeps all 28 bits
	assign scaled  = 28'(pendQ ^ `ADPWM_PCM_MID) * 28'(CYC12);

	// ----------------------------------------
	// Period counter
	// ----------------------------------------
	// one period, four per tick
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cntQ <= 12'h000;
		end else if (wrap) begin
			cntQ <= 12'h000;
		end else begin
			cntQ <= cntNext;
		end
	end

	// ----------------------------------------
	// Duty compare, double buffered
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pendQ <= `ADPWM_PCM_MID;
		end else if (cif.dutyLoad) begin
			pendQ <= cif.dutyWord;
		end
	end

	// boundary-only update
	// Late writes wait a period rather than cut the pulse short
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cmpQ <= 12'h000;
		end else if (wrap) begin
			cmpQ <= scaled[27:16];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pwmQ    <= 1'h0;
			perEndQ <= 1'h0;
		end else begin
			pwmQ    <= wrap ? (scaled[27:16] != 12'h000) : (cntNext < cmpQ);
			perEndQ <= wrap;
		end
	end

	assign cif.pwmLevel  = pwmQ;
	assign cif.periodEnd = perEndQ;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	cmp_at_edge_a: assert property ($changed(cmpQ) |-> $past(wrap))
		else $error("compare changed away from a period boundary");
	period_len_a: assert property (perEndQ |-> cntQ == 12'h000 ##1 !perEndQ)
		else $error("period end not aligned to counter restart");

endmodule

`default_nettype wire

// ---- logic/adpwm_pacer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adpwm_consts.svh"

// Notes on behaviour
// - Play press enters play request; acknowledge moves to playing.
// - Sample pacing event fires once per sample at 11.025 kHz.
// - Each pacing event while a segment is armed moves the next segment word into the duty compare.
// - Carrier runs at four times sample rate: four PWM periods per update.
// - Last word of a segment raises a segment-done pulse; next segment reloads.
// - Segments repeat until the final one drains; only then playback ends.
// - Record press enters record request; acknowledge moves to recording.
// - Recording stops on switch release or full memory, whichever first.
// - Record indicator lit exactly while recording.
// - Each sample tick while recording captures one conversion result.
// - Four 12-bit results become four 16-bit PCM words and flag ready.
// - Memory holds 27563 bytes, two samples each: 55126 samples.
// - Playing cannot be cancelled before the file ends.
module adpwm_pacer
	import adpwm_pkg::*;
	#(parameter int CARRIER_CYC = `ADPWM_CARRIER_CYC)
	(
	input  wire logic                     mclk,
	input  wire logic                     rst_b,
	input  wire logic                     playSwitch,
	input  wire logic                     recordSwitch,
	input  wire logic                     reqAck,
	input  wire logic                     segWrEn,
	input  wire logic [`ADPWM_SEG_AW-1:0] segWrAddr,
	input  wire logic [15:0]              segWrData,
	input  wire logic                     segGo,
	input  wire logic [`ADPWM_SEG_AW-1:0] segBase,
	input  wire logic [`ADPWM_SEG_AW:0]   segLen,
	input  wire logic                     segLast,
	input  wire logic [11:0]              adcData,
	input  wire logic [1:0]               pcmRdIdx,
	input  wire logic                     pcmTaken,
	output var  logic                     pwmOut,
	output var  logic                     playActive,
	output var  logic                     recordIndicator,
	output var  logic                     segDoneIrq,
	output var  logic [15:0]              pcmRdData,
	output var  logic                     pcmReady,
	output var  logic                     recMemFull,
	output var  logic [2:0]               ctrlState
	);

	localparam logic [15:0]            REC_MAX = 16'(`ADPWM_REC_SAMPLES);
	localparam logic [`ADPWM_SEG_AW:0] ONE_LEFT = (`ADPWM_SEG_AW+1)'(1);

	adpwm_carrier_if cif ();

	adpwm_state_t stateQ;
	adpwm_state_t stateD;
	logic [2:0]   playShQ;
	logic [2:0]   recShQ;
	logic         playPress;
	logic         recPress;
	logic         recHeld;
	logic [1:0]   qtrQ;
	logic         tickQ;
	logic [15:0]  segMem [0:`ADPWM_SEG_DEPTH-1];
	logic         armedQ;
	logic [`ADPWM_SEG_AW-1:0] rdPtrQ;
	logic [`ADPWM_SEG_AW:0]   remainQ;
	logic         lastSegQ;
	logic [15:0]  dutyWordQ;
	logic         dutyLoadQ;
	logic         segDoneQ;
	logic         lastXfer;
	logic         playEnd;
	logic [1:0]   grpCntQ;
	adpwm_adc_t   grpQ [0:2];
	adpwm_adc_t   rawVec [0:3];
	adpwm_pcm_t   pcmBufQ [0:3];
	logic [15:0]  sampleCntQ;
	logic         recFull;
	logic         recStop;
	logic         capture;
	logic         grpDone;
	logic         pcmReadyQ;
	logic [15:0]  pcmRdDataQ;
	logic         recFullQ;
	logic         playActiveQ;
	logic         recIndQ;

	// ----------------------------------------
	// Carrier timer
	// ----------------------------------------
	adpwm_carrier #(.CARRIER_CYC(CARRIER_CYC)) uCarrier (
		.mclk  (mclk),
		.rst_b (rst_b),
		.cif   (cif)
	);

	assign cif.dutyWord = dutyWordQ;
	assign cif.dutyLoad = dutyLoadQ;

	// ----------------------------------------
	// Switch synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			playShQ <= 3'h0;
			recShQ  <= 3'h0;
		end else begin
			playShQ <= {playShQ[1:0], playSwitch};
			recShQ  <= {recShQ[1:0], recordSwitch};
		end
	end

	// Bit 0 is the metastable stage; edges are taken from bits 1 and 2 only
	assign playPress = playShQ[1] & ~playShQ[2];
	assign recPress  = recShQ[1] & ~recShQ[2];
	assign recHeld   = recShQ[1];

	// ----------------------------------------
	// Sample pacing
	// ----------------------------------------
	// one tick per four periods
	// Deriving the tick from the carrier keeps both rates locked
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			qtrQ  <= 2'h0;
			tickQ <= 1'h0;
		end else begin
			if (cif.periodEnd) begin
				qtrQ <= qtrQ + 2'h1;
			end
			tickQ <= cif.periodEnd && (qtrQ == 2'h3);
		end
	end

	// ----------------------------------------
	// Control state machine
	// ----------------------------------------
	assign lastXfer = tickQ && armedQ && (remainQ == ONE_LEFT);
	assign playEnd  = lastXfer && lastSegQ;
	assign recFull  = (sampleCntQ == REC_MAX);
	assign recStop  = !recHeld || recFull;

	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_IDLE: begin
				if (playPress) begin
					stateD = ST_PLAY_REQ;
				end else if (recPress) begin
					stateD = ST_REC_REQ;
				end
			end
			ST_PLAY_REQ: begin
				if (reqAck) begin
					stateD = ST_PLAY_ACTIVE;
				end
			end
			ST_PLAY_ACTIVE: begin
				if (playEnd) begin
					stateD = ST_IDLE;
				end
			end
			ST_REC_REQ: begin
				if (reqAck) begin
					stateD = ST_RECORDING;
				end
			end
			ST_RECORDING: begin
				if (recStop) begin
					stateD = ST_REC_STOP;
				end
			end
			ST_REC_STOP: begin
				stateD = ST_IDLE;
			end
			default: begin
				stateD = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			stateQ      <= ST_IDLE;
			playActiveQ <= 1'h0;
			recIndQ     <= 1'h0;
		end else begin
			stateQ      <= stateD;
			playActiveQ <= (stateD == ST_PLAY_ACTIVE);
			recIndQ     <= (stateD == ST_RECORDING);
		end
	end

	// ----------------------------------------
	// Segment buffer and transfer engine
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (segWrEn) begin
			segMem[segWrAddr] <= segWrData;
		end
	end

	// arm, walk, disarm
	// A start while armed is ignored; software waits for the done pulse
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			armedQ   <= 1'h0;
			rdPtrQ   <= '0;
			remainQ  <= '0;
			lastSegQ <= 1'h0;
		end else if (stateQ != ST_PLAY_ACTIVE) begin
			armedQ <= 1'h0;
		end else if (segGo && !armedQ && (segLen != '0)) begin
			armedQ   <= 1'h1;
			rdPtrQ   <= segBase;
			remainQ  <= segLen;
			lastSegQ <= segLast;
		end else if (tickQ && armedQ) begin
			rdPtrQ  <= rdPtrQ + 1'h1;
			remainQ <= remainQ - ONE_LEFT;
			if (remainQ == ONE_LEFT) begin
				armedQ <= 1'h0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dutyWordQ <= `ADPWM_PCM_MID;
			dutyLoadQ <= 1'h0;
			segDoneQ  <= 1'h0;
		end else begin
			if (tickQ && armedQ) begin
				dutyWordQ <= segMem[rdPtrQ];
			end
			dutyLoadQ <= tickQ && armedQ;
			segDoneQ  <= lastXfer;
		end
	end

	// ----------------------------------------
	// Capture and PCM grouping
	// ----------------------------------------
	// one result per tick
	assign capture = (stateQ == ST_RECORDING) && tickQ && !recStop;
	assign grpDone = capture && (grpCntQ == 2'h3);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sampleCntQ <= 16'h0000;
			grpCntQ    <= 2'h0;
			recFullQ   <= 1'h0;
		end else begin
			if ((stateQ == ST_REC_REQ) && reqAck) begin
				sampleCntQ <= 16'h0000;
				grpCntQ    <= 2'h0;
			end else if (capture) begin
				sampleCntQ <= sampleCntQ + 16'h0001;
				grpCntQ    <= grpCntQ + 2'h1;
			end
			recFullQ <= recFull;
		end
	end

	// group of four to PCM
	// Fourth result goes straight from the port so the group closes on its tick
	for (genvar i = 0; i < `ADPWM_GROUP_LEN; i++) begin : gEntry
		if (i < `ADPWM_GROUP_LEN - 1) begin : gHold
			always_ff @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					grpQ[i] <= 12'h000;
				end else if (capture && (grpCntQ == 2'(i))) begin
					grpQ[i] <= adcData;
				end
			end
			assign rawVec[i] = grpQ[i];
		end else begin : gLive
			assign rawVec[i] = adcData;
		end
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				pcmBufQ[i] <= 16'h0000;
			end else if (grpDone) begin
				pcmBufQ[i] <= {~rawVec[i][11], rawVec[i][10:0], 4'h0};
			end
		end
	end

	// Set wins over a same-cycle take
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pcmReadyQ  <= 1'h0;
			pcmRdDataQ <= 16'h0000;
		end else begin
			if (grpDone) begin
				pcmReadyQ <= 1'h1;
			end else if (pcmTaken) begin
				pcmReadyQ <= 1'h0;
			end
			pcmRdDataQ <= pcmBufQ[pcmRdIdx];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pwmOut          = cif.pwmLevel;
	assign playActive      = playActiveQ;
	assign recordIndicator = recIndQ;
	assign segDoneIrq      = segDoneQ;
	assign pcmRdData       = pcmRdDataQ;
	assign pcmReady        = pcmReadyQ;
	assign recMemFull      = recFullQ;
	assign ctrlState       = stateQ;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	int   sinceTickQ;
	logic [2:0] perSinceQ;
	logic seenTickQ;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sinceTickQ <= 0;
			perSinceQ  <= 3'h0;
			seenTickQ  <= 1'h0;
		end else if (tickQ) begin
			sinceTickQ <= 0;
			perSinceQ  <= 3'h0;
			seenTickQ  <= 1'h1;
		end else begin
			sinceTickQ <= sinceTickQ + 1;
			perSinceQ  <= perSinceQ + {2'h0, cif.periodEnd};
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence playReqS;
		stateQ == ST_IDLE && playPress;
	endsequence
	sequence recReqS;
		stateQ == ST_IDLE && recPress && !playPress;
	endsequence

	play_request_a: assert property (playReqS |=> stateQ == ST_PLAY_REQ)
		else $error("play press not followed by play request");
	play_ack_a: assert property (stateQ == ST_PLAY_REQ && reqAck |=> stateQ == ST_PLAY_ACTIVE && playActive)
		else $error("acknowledged play request did not start playing");
	tick_rate_a: assert property (tickQ && seenTickQ |-> sinceTickQ == 4 * CARRIER_CYC - 1)
		else $error("sample tick spacing wrong");
	four_periods_a: assert property (tickQ && seenTickQ |-> perSinceQ == 3'h4)
		else $error("not four carrier periods per sample");
	duty_fetch_a: assert property (tickQ && armedQ |=> dutyLoadQ && dutyWordQ == segMem[$past(rdPtrQ)])
		else $error("pacing event did not load duty word");
	seg_done_a: assert property (lastXfer |=> segDoneIrq && !armedQ ##1 !segDoneIrq)
		else $error("segment end pulse missing");
	play_hold_a: assert property (stateQ == ST_PLAY_ACTIVE && !playEnd |=> stateQ == ST_PLAY_ACTIVE)
		else $error("playback left before file end");
	play_end_a: assert property (playEnd |=> stateQ == ST_IDLE ##1 !segDoneIrq)
		else $error("playback did not end after final segment");
	rec_request_a: assert property (recReqS |=> stateQ == ST_REC_REQ)
		else $error("record press not followed by record request");
	rec_stop_a: assert property (stateQ == ST_RECORDING && recStop |=> stateQ == ST_REC_STOP ##1 stateQ == ST_IDLE)
		else $error("recording did not stop");
	rec_led_a: assert property (recordIndicator == (stateQ == ST_RECORDING))
		else $error("record indicator out of step");
	rec_capture_a: assert property (capture |=> sampleCntQ == $past(sampleCntQ) + 16'h0001)
		else $error("tick did not capture a sample");
	pcm_group_a: assert property (grpDone |=> pcmReady && pcmBufQ[3][15:4] == {~$past(adcData[11]), $past(adcData[10:0])})
		else $error("group of four not packed");
	rec_bound_a: assert property (sampleCntQ <= REC_MAX)
		else $error("recording ran past memory");

endmodule

`default_nettype wire

// ---- dv/adpwm_lpf_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Speaker-side low-pass filter model
// ----------------------------------------
// First-order IIR; shift of 3 trades ripple for a short settle time
module adpwm_lpf_model (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       pwmIn,
	output var  logic [7:0] level
	);
	logic [10:0] accQ;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			accQ <= 11'h000;
		end else begin
			accQ <= accQ - (accQ >> 3) + (pwmIn ? 11'h0FF : 11'h000);
		end
	end

	assign level = accQ[10:3];
endmodule

`default_nettype wire

// ---- dv/adpwm_pwm_audio_pacer_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module adpcm_pwm_audio_pacer_tb_top
	import adpwm_pkg::*;
	;
	// Small carrier so a sample tick is 32 cycles
	localparam int CC = 8;
	localparam int TICK = 4 * CC;

	logic        mclk, rst_b, playSwitch, recordSwitch, reqAck;
	logic        segWrEn, segGo, segLast, pcmTaken;
	logic [6:0]  segWrAddr, segBase;
	logic [7:0]  segLen;
	logic [15:0] segWrData, pcmRdData;
	logic [11:0] adcData;
	logic [1:0]  pcmRdIdx;
	logic        pwmOut, playActive, recordIndicator, segDoneIrq, pcmReady, recMemFull;
	logic [2:0]  ctrlState;
	logic [7:0]  lpfLevel;
	int          fails, nTests;

	adpwm_pacer #(.CARRIER_CYC(CC)) i_dut (.mclk(mclk), .rst_b(rst_b), .playSwitch(playSwitch),
		.recordSwitch(recordSwitch), .reqAck(reqAck), .segWrEn(segWrEn), .segWrAddr(segWrAddr),
		.segWrData(segWrData), .segGo(segGo), .segBase(segBase), .segLen(segLen), .segLast(segLast),
		.adcData(adcData), .pcmRdIdx(pcmRdIdx), .pcmTaken(pcmTaken), .pwmOut(pwmOut),
		.playActive(playActive), .recordIndicator(recordIndicator), .segDoneIrq(segDoneIrq),
		.pcmRdData(pcmRdData), .pcmReady(pcmReady), .recMemFull(recMemFull), .ctrlState(ctrlState));

	adpwm_lpf_model i_lpf (.mclk(mclk), .rst_b(rst_b), .pwmIn(pwmOut), .level(lpfLevel));

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude();
		if (fails == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic countHigh(input int n, output int h);
		h = 0;
		repeat (n) begin
			@(negedge mclk);
			h += int'(pwmOut);
		end
	endtask

	// Segment go at this negedge; cycles counted up to the done pulse
	task automatic segRun(input logic [6:0] b, input logic [7:0] l, input logic last, output int c);
		segBase = b;
		segLen = l;
		segLast = last;
		segGo = 1'b1;
		c = 0;
		@(negedge mclk);
		segGo = 1'b0;
		c = 1;
		while (segDoneIrq !== 1'b1 && c < 400) begin
			@(negedge mclk);
			c++;
		end
	endtask

	// Press and acknowledge; request state must appear before the ack
	task automatic pressAck(input logic rec, input logic [2:0] reqSt, input logic [2:0] actSt);
		if (rec) recordSwitch = 1'b1;
		else playSwitch = 1'b1;
		cyc(4);
		`CHK("request state", reqSt, ctrlState)
		reqAck = 1'b1;
		cyc(2);
		reqAck = 1'b0;
		`CHK("active state", actSt, ctrlState)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testReset();
		`CHK("reset state", 3'(ST_IDLE), ctrlState)
		`CHK("reset pwm", 1'b0, pwmOut)
		`CHK("reset rec led", 1'b0, recordIndicator)
		`CHK("reset ready", 1'b0, pcmReady)
		`CHK("reset full", 1'b0, recMemFull)
	endtask

	task automatic testPlay();
		int h, c;
		pressAck(1'b0, 3'(ST_PLAY_REQ), 3'(ST_PLAY_ACTIVE));
		`CHK("play level", 1'b1, playActive)
		playSwitch = 1'b0;
		for (int i = 0; i < 3; i++) begin
			segWrEn = 1'b1;
			segWrAddr = 7'(i);
			segWrData = (i == 2) ? 16'h8000 : 16'h7FFF;
			cyc(1);
		end
		segWrEn = 1'b0;
		segRun(7'h00, 8'h02, 1'b0, c);
		`CHK("irq two words", 1'b1, c > TICK && c <= 3 * TICK)
		cyc(1);
		`CHK("irq one cycle", 1'b0, segDoneIrq)
		// Full-scale word gives compare 7 of 8: four periods per tick
		countHigh(TICK, h);
		`CHK("duty high count", 28, h)
		`CHK("filter level", 1'b1, lpfLevel > 8'hA0)
		// Presses while playing are ignored
		recordSwitch = 1'b1;
		playSwitch = 1'b1;
		cyc(6);
		`CHK("play not cancelled", 3'(ST_PLAY_ACTIVE), ctrlState)
		recordSwitch = 1'b0;
		playSwitch = 1'b0;
		// Back-to-back segments: done pulses one tick apart
		segRun(7'h01, 8'h01, 1'b0, c);
		segRun(7'h01, 8'h01, 1'b0, c);
		`CHK("tick spacing", TICK, c)
		`CHK("still playing", 3'(ST_PLAY_ACTIVE), ctrlState)
		segRun(7'h02, 8'h01, 1'b1, c);
		`CHK("done state", 3'(ST_IDLE), ctrlState)
		`CHK("done level", 1'b0, playActive)
		cyc(CC);
		countHigh(TICK, h);
		`CHK("midscale silent", 0, h)
	endtask

	task automatic testRecord();
		int c;
		adcData = 12'hABC;
		pressAck(1'b1, 3'(ST_REC_REQ), 3'(ST_RECORDING));
		`CHK("rec led on", 1'b1, recordIndicator)
		c = 0;
		while (pcmReady !== 1'b1 && c < 400) begin
			cyc(1);
			c++;
		end
		// Four captures at one per tick, tick phase unknown
		`CHK("group time", 1'b1, c > 3 * TICK && c <= 4 * TICK + 4)
		for (int i = 0; i < 4; i++) begin
			pcmRdIdx = 2'(i);
			cyc(2);
			`CHK("pcm word", 16'h2BC0, pcmRdData)
		end
		pcmTaken = 1'b1;
		cyc(1);
		pcmTaken = 1'b0;
		cyc(1);
		`CHK("ready cleared", 1'b0, pcmReady)
		// Memory-full stop needs 55126 ticks; too long here, release stop only
		recordSwitch = 1'b0;
		c = 0;
		while (ctrlState === 3'(ST_RECORDING) && c < 8) begin
			cyc(1);
			c++;
		end
		`CHK("rec stop state", 3'(ST_REC_STOP), ctrlState)
		`CHK("rec led off", 1'b0, recordIndicator)
		cyc(1);
		`CHK("back to idle", 3'(ST_IDLE), ctrlState)
		`CHK("not full", 1'b0, recMemFull)
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		fails = 0;
		nTests = 0;
		rst_b = 1'b0;
		{playSwitch, recordSwitch, reqAck, segWrEn, segGo, segLast, pcmTaken} = 7'h00;
		segWrAddr = 7'h00;
		segBase = 7'h00;
		segLen = 8'h00;
		segWrData = 16'h0000;
		adcData = 12'h000;
		pcmRdIdx = 2'h0;
		cyc(20);
		rst_b = 1'b1;
		cyc(2);
		testReset();
		testPlay();
		testRecord();
		conclude();
	end

	initial begin
		#(8 * 20000);
		fails++;
		conclude();
	end
endmodule

`default_nettype wire
